// ---- rtl/rcd_drive_ctrl.sv ----
// Drive strength, input termination and power saving control words behind APB
//
// Decided for this implementation: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "rcd_drive_params.svh"
module rcd_drive_ctrl
  import rcd_drive_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Device pins
  input wire pin_set_t pins,
  // Decoded settings
  output var drive_set_t drive_set,
  output var term_state_t term_state,
  output logic weak_drive,
  output logic power_down,
  output logic [1:0] odt_outputs
);

  // Every assertion in this block runs on the one system clock and sleeps in reset
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  // ----------------------------------------
  // Functions
  // ----------------------------------------

  // Reserved codes leave the previous drive in place rather than guess a strength
  function automatic drive_t decode_drive(input logic [1:0] code, input logic strong_ok, input drive_t prev);
    drive_t res;
    res = prev;
    case (code)
      `DRIVE_CODE_LIGHT: res = drive_light;
      `DRIVE_CODE_MODERATE: res = drive_moderate;
      `DRIVE_CODE_STRONG: res = strong_ok ? drive_strong : prev;
      default: res = prev;
    endcase
    return res;
  endfunction : decode_drive

  // Reserved termination codes fall to off, the safe side for the bus
  function automatic term_value_t decode_term(input logic [2:0] code, input logic sel150);
    term_value_t res;
    res = term_off;
    case (code)
      `TERM_CODE_KEEP: res = sel150 ? term_150 : term_100;
      `TERM_CODE_200: res = term_200;
      `TERM_CODE_300: res = term_300;
      default: res = term_off;
    endcase
    return res;
  endfunction : decode_term

  function automatic logic is_addr(input logic [11:0] addr, input logic [11:0] ofs);
    return addr == ofs;
  endfunction : is_addr

  // ----------------------------------------
  // Pin synchronisation and bus strobes
  // ----------------------------------------

  pin_set_t pins_s;
  logic [3:0] ca_word;
  logic [3:0] ctrl_word;
  logic [3:0] clk_word;
  logic [3:0] term_word;
  logic [3:0] power_word;
  logic [1:0] host_cfg;
  logic in_pd;
  logic access;
  logic commit_wr;
  logic mapped;
  logic [31:0] next_rdata;

  pin_sync u_pin_sync (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .pins_async(pins),
    .pins_sync(pins_s)
  );

  assign access = psel && penable;
  assign commit_wr = access && pready && pwrite;
  assign mapped = paddr <= `OFS_STATUS && paddr[1:0] == 2'h0;

  // ----------------------------------------
  // APB handshake
  // ----------------------------------------

  // One wait state keeps pready, prdata and pslverr all registered
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= access && !pready;
      pslverr <= access && !pready && !mapped;
    end
  end

  // Drive, termination and power words are write-only; their reads return zero
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (is_addr(paddr, `OFS_HOST_CONFIG)) begin
      next_rdata[1:0] = host_cfg;
    end else if (is_addr(paddr, `OFS_STATUS)) begin
      next_rdata[0] = power_down;
      next_rdata[1] = weak_drive;
      next_rdata[2] = term_state.general_on;
      next_rdata[3] = term_state.cs_odt_on;
      next_rdata[6:4] = term_state.value;
      next_rdata[7] = pins_s.mirror;
      next_rdata[9:8] = odt_outputs;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h0000_0000;
    end else if (access && !pready) begin
      prdata <= pwrite ? 32'h0000_0000 : next_rdata;
    end
  end

  // ----------------------------------------
  // Control words
  // ----------------------------------------

  // Drive words hold until rewritten
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ca_word <= `WORD_RESET;
      ctrl_word <= `WORD_RESET;
      clk_word <= `WORD_RESET;
    end else if (commit_wr) begin
      if (is_addr(paddr, `OFS_CA_DRIVE)) begin
        ca_word <= pwdata[3:0];
      end
      if (is_addr(paddr, `OFS_CTRL_DRIVE)) begin
        ctrl_word <= pwdata[3:0];
      end
      if (is_addr(paddr, `OFS_CLK_DRIVE)) begin
        clk_word <= pwdata[3:0];
      end
    end
  end

  // Termination and power words
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      term_word <= `WORD_RESET;
      power_word <= `WORD_RESET;
    end else if (commit_wr) begin
      if (is_addr(paddr, `OFS_EXTRA_TERM)) begin
        term_word <= pwdata[3:0];
      end
      if (is_addr(paddr, `OFS_POWER_SAVE)) begin
        power_word <= pwdata[3:0];
      end
    end
  end

  // Global float and timing-word termination choice, mirrored here as inputs to the decode
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      host_cfg <= `CFG_RESET;
    end else if (commit_wr && is_addr(paddr, `OFS_HOST_CONFIG)) begin
      host_cfg <= pwdata[1:0];
    end
  end

  // ----------------------------------------
  // Drive strength outputs
  // ----------------------------------------

  // Three groups, each with its own word and two halves
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      drive_set <= drive_set_t'({drive_light, drive_light, drive_light, drive_light, drive_light, drive_light});
    end else begin
      drive_set.ca_a <= decode_drive(ca_word[1:0], 1'b1, drive_set.ca_a);
      drive_set.ca_b <= decode_drive(ca_word[3:2], 1'b1, drive_set.ca_b);
      drive_set.ctrl_a <= decode_drive(ctrl_word[1:0], 1'b0, drive_set.ctrl_a);
      drive_set.ctrl_b <= decode_drive(ctrl_word[3:2], 1'b0, drive_set.ctrl_b);
      drive_set.clk_13 <= decode_drive(clk_word[1:0], 1'b1, drive_set.clk_13);
      drive_set.clk_02 <= decode_drive(clk_word[3:2], 1'b1, drive_set.clk_02);
    end
  end

  // ----------------------------------------
  // Input termination
  // ----------------------------------------

  logic term_any_bit;
  logic term_off_code;
  logic pd_term_off;
  logic mirror_kill;
  logic next_general_on;
  logic next_cs_odt_on;

  assign term_any_bit = |term_word[2:0];
  assign term_off_code = term_word[2:0] == `TERM_CODE_OFF;
  assign pd_term_off = in_pd && power_word[`PWR_PD_MODE_BIT];
  // Back-side register: keep bit spares it only while the low code bits are clear
  assign mirror_kill = pins_s.mirror && (!term_word[`TERM_MIRROR_KEEP_BIT] || term_any_bit);
  assign next_general_on = !term_off_code && !pd_term_off && !mirror_kill;
  // Any set code bit on a back-side register drops every input, chip selects included
  assign next_cs_odt_on = !term_off_code && !pd_term_off && !(pins_s.mirror && term_any_bit);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      term_state <= term_state_t'({1'b1, 1'b1, term_100});
    end else begin
      term_state.general_on <= next_general_on;
      term_state.cs_odt_on <= next_cs_odt_on;
      term_state.value <= decode_term(term_word[2:0], host_cfg[`CFG_TERM150_BIT]);
    end
  end

  // ----------------------------------------
  // Power saving
  // ----------------------------------------

  power_down_ctrl u_power_down_ctrl (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .pd_enable(power_word[`PWR_PD_ENABLE_BIT]),
    .cke0(pins_s.cke0),
    .cke1(pins_s.cke1),
    .in_power_down(in_pd)
  );

  // Weak drive is only a variant of float, so it needs float set as well
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      weak_drive <= 1'b0;
      power_down <= 1'b0;
    end else begin
      weak_drive <= power_word[`PWR_WEAK_BIT] && host_cfg[`CFG_FLOAT_BIT] && (&pins_s.cs_n);
      power_down <= in_pd;
    end
  end

  // ODT passes through unless the power-down mode holds it low
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      odt_outputs <= 2'h0;
    end else begin
      odt_outputs <= pd_term_off ? 2'h0 : pins_s.odt;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------

  sequence apb_write_to(logic [11:0] ofs);
    psel && !penable && pwrite && paddr == ofs ##1 access && !pready ##1 access && pready;
  endsequence

  sequence both_cke_low;
    pins_s.cke0 == 1'b0 && pins_s.cke1 == 1'b0;
  endsequence

  a_pready_one_wait: assert property (access && !pready |=> pready ##1 !pready)
    else $error("pready not raised one cycle into access");
  a_ca_word_store: assert property (apb_write_to(`OFS_CA_DRIVE) |=> ca_word == $past(pwdata[3:0]))
    else $error("address drive word not captured");
  a_ca_strong_drive: assert property (ca_word[3:2] == `DRIVE_CODE_STRONG |=> drive_set.ca_b == drive_strong)
    else $error("address side B not strong");
  a_ctrl_reserved_hold: assert property (ctrl_word[1:0] == `DRIVE_CODE_STRONG |=> $stable(drive_set.ctrl_a))
    else $error("control drive changed on reserved code");
  a_clk_moderate: assert property (clk_word[1:0] == `DRIVE_CODE_MODERATE |=> drive_set.clk_13 == drive_moderate)
    else $error("clock outputs 1 and 3 not moderate");
  a_mirror_cs_kept: assert property (pins_s.mirror && !term_any_bit && !pd_term_off |=>
      !term_state.general_on && term_state.cs_odt_on == !$past(term_word[`TERM_MIRROR_KEEP_BIT]) ||
      term_state.cs_odt_on && term_state.general_on == $past(term_word[`TERM_MIRROR_KEEP_BIT]))
    else $error("back-side termination wrong");
  a_mirror_any_bit: assert property (pins_s.mirror && term_any_bit |=> !term_state.general_on && !term_state.cs_odt_on)
    else $error("termination on with code bit and back-side pin");
  a_off_code_all: assert property (term_off_code |=> !term_state.general_on && !term_state.cs_odt_on &&
      term_state.value == term_off)
    else $error("off code left termination on");
  a_term_value_300: assert property (term_word[2:0] == `TERM_CODE_300 |=> term_state.value == term_300)
    else $error("300 ohm code not decoded");
  a_weak_needs_float: assert property (weak_drive |-> $past(host_cfg[`CFG_FLOAT_BIT]) && $past(&pins_s.cs_n))
    else $error("weak drive without float or with a chip select low");
  a_pd_entry: assert property ((power_word[`PWR_PD_ENABLE_BIT] and both_cke_low) |=> in_pd ##1 power_down)
    else $error("power-down not entered");
  a_pd_disabled: assert property (!power_word[`PWR_PD_ENABLE_BIT] |=> !in_pd)
    else $error("power-down entered while disabled");
  a_pd_odt_low: assert property (in_pd && power_word[`PWR_PD_MODE_BIT] |=> odt_outputs == 2'h0 && !term_state.general_on)
    else $error("ODT not held low in power-down");
  a_pd_odt_follow: assert property (in_pd && !power_word[`PWR_PD_MODE_BIT] |=> odt_outputs == $past(pins_s.odt))
    else $error("ODT not following input in power-down");

endmodule : rcd_drive_ctrl
`default_nettype wire

// ---- inc/rcd_drive_params.svh ----
// Offsets, field positions, reset values, codes and widths of the drive and termination control block
`ifndef RCD_DRIVE_PARAMS_SVH
`define RCD_DRIVE_PARAMS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define OFS_CA_DRIVE 12'h000
`define OFS_CTRL_DRIVE 12'h004
`define OFS_CLK_DRIVE 12'h008
`define OFS_EXTRA_TERM 12'h00c
`define OFS_POWER_SAVE 12'h010
`define OFS_HOST_CONFIG 12'h014
`define OFS_STATUS 12'h018

// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define WORD_RESET 4'h0
`define CFG_RESET 2'h0
`define CFG_FLOAT_BIT 0
`define CFG_TERM150_BIT 1
`define TERM_MIRROR_KEEP_BIT 3
`define PWR_WEAK_BIT 0
`define PWR_PD_MODE_BIT 2
`define PWR_PD_ENABLE_BIT 3
`define TERM_CODE_KEEP 3'h0
`define TERM_CODE_200 3'h2
`define TERM_CODE_300 3'h4
`define TERM_CODE_OFF 3'h7
`define DRIVE_CODE_LIGHT 2'h0
`define DRIVE_CODE_MODERATE 2'h1
`define DRIVE_CODE_STRONG 2'h2
`define SYNC_WIDTH 9

`endif

// ---- inc/rcd_drive_pkg.sv ----
// Types shared by the drive and termination control block
`default_nettype none
package rcd_drive_pkg;

  typedef enum logic [1:0] {drive_light, drive_moderate, drive_strong} drive_t;

  typedef enum logic [2:0] {term_100, term_150, term_200, term_300, term_off} term_value_t;

  typedef struct packed {
    drive_t ca_a;
    drive_t ca_b;
    drive_t ctrl_a;
    drive_t ctrl_b;
    drive_t clk_13;
    drive_t clk_02;
  } drive_set_t;

  typedef struct packed {
    logic general_on;
    logic cs_odt_on;
    term_value_t value;
  } term_state_t;

  typedef struct packed {
    logic mirror;
    logic [3:0] cs_n;
    logic cke0;
    logic cke1;
    logic [1:0] odt;
  } pin_set_t;

endpackage : rcd_drive_pkg
`default_nettype wire

// ---- rtl/pin_sync.sv ----
// Two-stage synchroniser for the device pins
`timescale 1ns/1ps
`default_nettype none
module pin_sync
  import rcd_drive_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Pins in and synchronised out
  input wire pin_set_t pins_async,
  output var pin_set_t pins_sync
);

  pin_set_t stage1;

  // Chip selects idle high so that reset does not look like a selected state
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      stage1 <= pin_set_t'({1'b0, 4'hf, 1'b1, 1'b1, 2'h0});
      pins_sync <= pin_set_t'({1'b0, 4'hf, 1'b1, 1'b1, 2'h0});
    end else begin
      stage1 <= pins_async;
      pins_sync <= stage1;
    end
  end

endmodule : pin_sync
`default_nettype wire

// ---- rtl/power_down_ctrl.sv ----
// CKE power-down entry and exit tracking
`timescale 1ns/1ps
`default_nettype none
module power_down_ctrl (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Setting and synchronised clock enables
  input wire logic pd_enable,
  input wire logic cke0,
  input wire logic cke1,
  // State
  output logic in_power_down
);

  // Both clock enables must be low; a disabled feature never enters
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      in_power_down <= 1'b0;
    end else begin
      in_power_down <= pd_enable && !cke0 && !cke1;
    end
  end

endmodule : power_down_ctrl
`default_nettype wire

// ---- test/dram_side_pins.sv ----
// Controller side model that drives the register's asynchronous control pins
`timescale 1ns/1ps
`default_nettype none
module dram_side_pins
  import rcd_drive_pkg::*;
(
  // Clock
  input wire logic sys_clk,
  // Levels requested by the bench
  input wire logic mirror_req,
  input wire logic deselect_req,
  input wire logic cke_low_req,
  input wire logic [1:0] odt_req,
  // Pins toward the register
  output var pin_set_t pins
);
  // Idle levels at time zero: all deselected, clock enables high
  initial begin
    pins = '{mirror: 1'b0, cs_n: 4'hf, cke0: 1'b1, cke1: 1'b1, odt: 2'h0};
  end

  // Pins move just after a rising edge, as a controller's flops would
  always @(posedge sys_clk) begin
    pins.mirror <= mirror_req;
    pins.cs_n <= deselect_req ? 4'hf : 4'he;
    pins.cke0 <= !cke_low_req;
    pins.cke1 <= !cke_low_req;
    pins.odt <= odt_req;
  end
endmodule : dram_side_pins
`default_nettype wire

// ---- test/tb_rcd_drive_ctrl.sv ----
// Self-checking bench for the drive, termination and power saving control words
`timescale 1ns/1ps
`default_nettype none
`include "rcd_drive_params.svh"
module tb_rcd_drive_ctrl
  import rcd_drive_pkg::*;
;
  logic sys_clk, rst_n, psel, penable, pwrite, pready, pslverr, weak_drive, power_down, err;
  logic [11:0] paddr, exp_drv;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0] odt_outputs, odt_req;
  logic mirror_req, deselect_req, cke_low_req;
  pin_set_t pins;
  drive_set_t drive_set;
  term_state_t term_state;
  int n_fail = 0;
  int checks_done = 0;
  int cyc = 0;

  rcd_drive_ctrl rcd_drive_ctrl_inst (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pins(pins), .drive_set(drive_set), .term_state(term_state), .weak_drive(weak_drive),
    .power_down(power_down), .odt_outputs(odt_outputs));
  dram_side_pins dram_side_pins_inst (.sys_clk(sys_clk), .mirror_req(mirror_req), .deselect_req(deselect_req),
    .cke_low_req(cke_low_req), .odt_req(odt_req), .pins(pins));

  // ----------------------------------------
  // Clock, timeout and verdict
  // ----------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  // A hung handshake would otherwise stall the run forever
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      final_report();
    end
  end

  task automatic final_report;
    if (n_fail == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : final_report

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // ----------------------------------------
  // Bus and pin tasks
  // ----------------------------------------
  // Request is held until the edge where pready is seen high; only the bench timeout ends a hung wait
  task automatic apb(input logic wr_en, input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr_en;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    // Values read right after the edge are those the slave's flops presented at it
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Settling covers the two synchroniser stages plus output flops
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    repeat (8) @(negedge sys_clk);
  endtask : wr

  task automatic pin(input logic m, input logic des, input logic ckl, input logic [1:0] odt);
    @(posedge sys_clk);
    mirror_req <= m;
    deselect_req <= des;
    cke_low_req <= ckl;
    odt_req <= odt;
    repeat (8) @(negedge sys_clk);
  endtask : pin

  // Reserved codes must leave the previous drive in place
  task automatic wr_drive(input int w, input logic [1:0] a, input logic [1:0] b);
    wr(12'(`OFS_CA_DRIVE + 4 * w), {28'h0, b, a});
    if (a != 2'h3 && !(w == 1 && a == 2'h2)) exp_drv[11 - 4 * w -: 2] = a;
    if (b != 2'h3 && !(w == 1 && b == 2'h2)) exp_drv[9 - 4 * w -: 2] = b;
    chk("drive_set", 32'(drive_set), 32'(exp_drv));
  endtask : wr_drive

  task automatic term_case(input logic m, input logic [3:0] w, input logic [4:0] exp);
    pin(m, 1'b1, 1'b0, 2'h0);
    wr(`OFS_EXTRA_TERM, {28'h0, w});
    chk("term_state", 32'(term_state), 32'(exp));
  endtask : term_case

  task automatic pwr_case(input logic [1:0] hc, input logic [3:0] pw, input logic des, input logic ckl,
                          input logic [1:0] odt, input logic [8:0] exp);
    pin(1'b0, des, ckl, odt);
    wr(`OFS_HOST_CONFIG, {30'h0, hc});
    wr(`OFS_POWER_SAVE, {28'h0, pw});
    chk("power_outputs", 32'({power_down, weak_drive, odt_outputs, term_state}), 32'(exp));
  endtask : pwr_case

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    rst_n = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {mirror_req, cke_low_req, odt_req} = '0;
    deselect_req = 1'b1;
    exp_drv = 12'h000;
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(negedge sys_clk);
    chk("reset_outputs", 32'({power_down, weak_drive, odt_outputs, term_state, drive_set}), 32'h18000);
    for (int w = 0; w < 3; w++) begin
      for (int c = 0; c < 4; c++) begin
        wr_drive(w, 2'(c), 2'((c + 1) % 4));
      end
    end
    apb(1'b0, `OFS_CA_DRIVE, 32'h0);
    chk("wo_read", {rd[30:0], err}, 32'h0);
    apb(1'b0, 12'h01c, 32'h0);
    chk("unmapped_err", {rd[30:0], err}, 32'h1);
    apb(1'b1, 12'h020, 32'hf);
    chk("drive_set", 32'(drive_set), 32'(exp_drv));
    wr(`OFS_HOST_CONFIG, 32'h2);
    term_case(1'b0, 4'h0, 5'b11_001);
    term_case(1'b0, 4'h2, 5'b11_010);
    term_case(1'b0, 4'h4, 5'b11_011);
    term_case(1'b0, 4'h1, 5'b11_100);
    term_case(1'b0, 4'h7, 5'b00_100);
    term_case(1'b1, 4'h0, 5'b01_001);
    term_case(1'b1, 4'h8, 5'b11_001);
    term_case(1'b1, 4'ha, 5'b00_010);
    term_case(1'b1, 4'h7, 5'b00_100);
    term_case(1'b0, 4'h0, 5'b11_001);
    pwr_case(2'h3, 4'h1, 1'b1, 1'b0, 2'h0, 9'b0_1_00_11001);
    pwr_case(2'h3, 4'h1, 1'b0, 1'b0, 2'h0, 9'b0_0_00_11001);
    pwr_case(2'h2, 4'h1, 1'b1, 1'b0, 2'h0, 9'b0_0_00_11001);
    pwr_case(2'h3, 4'h0, 1'b1, 1'b0, 2'h0, 9'b0_0_00_11001);
    pwr_case(2'h2, 4'h8, 1'b1, 1'b0, 2'h2, 9'b0_0_10_11001);
    pwr_case(2'h2, 4'h8, 1'b1, 1'b1, 2'h2, 9'b1_0_10_11001);
    pwr_case(2'h2, 4'hc, 1'b1, 1'b1, 2'h2, 9'b1_0_00_00001);
    pwr_case(2'h2, 4'h4, 1'b1, 1'b1, 2'h2, 9'b0_0_10_11001);
    pwr_case(2'h2, 4'h8, 1'b1, 1'b0, 2'h1, 9'b0_0_01_11001);
    apb(1'b0, `OFS_HOST_CONFIG, 32'h0);
    chk("host_cfg_read", {rd[30:0], err}, 32'h4);
    apb(1'b0, `OFS_STATUS, 32'h0);
    chk("status_read", {rd[30:0], err}, 32'h238);
    final_report();
  end
endmodule : tb_rcd_drive_ctrl
`default_nettype wire
